// file: rtl/lcdx_tick_div.sv
`timescale 1ns/100ps
package lcdx_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Half period of the shift strobe toward the extension driver
  localparam int TICK_NS = 160;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 8;
  localparam int RAM_BYTES = 32;
  localparam int ADDR_W = 5;
  localparam int NUM_COM = 4;
  localparam int NUM_SEG = 64;
  localparam int INT_SEG = 32;
  localparam int SEG_IDX_W = 6;
  localparam logic [5:0] LAST_SEG_IDX = 6'h3F;
  localparam logic [7:0] RAM_RESET = 8'h00;
  // Zero-based pin indices of the shared segment pins
  localparam int POL_PIN = 28;
  localparam int DATA_PIN = 29;
  localparam int SHIFT_PIN = 30;
  localparam int LATCH_PIN = 31;
  typedef enum logic [1:0] {ST_SETUP, ST_CLK_HI, ST_LATCH} lcdx_state_t;
endpackage

module lcdx_tick_div (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  logic [lcdx_pkg::TICK_CNT_W-1:0] cnt_reg;
  logic [lcdx_pkg::TICK_CNT_W-1:0] cnt_next;
  logic tick_next;

  always_comb begin
    tick_next = 1'b0;
    cnt_next = cnt_reg + 8'h01;
    if (cnt_reg == 8'(lcdx_pkg::TICK_CYCLES - 1)) begin
      cnt_next = 8'h00;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick <= tick_next;
    end
  end
endmodule

// file: rtl/lcdx_ctrl.sv
`timescale 1ns/100ps
// Behaviour
// (RL1) Panel runs four commons at quarter duty, data also sent out serially.
// (RL2) Byte n holds segment 2n+1 in its low nibble, 2n+2 in its high one.
// (RL3) In each nibble the top bit is common four, the bottom bit common one.
// (RL4) A one in display memory lights the element at its segment and common.
// (RL5) A zero in display memory leaves its element dark.
// (RL6) Software sets the leftmost digit through the first two bytes.
// (RL7) 32 segments come from internal pins, 64 in all via the extension; the code drives 28, pins 28 to 31 carry extension signals.
// (RL8) Pins 32, 31, 30, 29 carry latch, shift, serial data and polarity.
// (RL9) Display memory takes byte and word writes like plain RAM.
module lcdx_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic cpu_wr_en,
  input wire logic cpu_rd_en,
  input wire logic cpu_word,
  input wire logic [4:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  output logic [3:0] com_out,
  output logic [31:0] seg_out,
  output logic row_latch_strobe,
  output logic shift_strobe,
  output logic serial_pixel_out,
  output logic polarity_out
);
  // Byte of RAM, nibble, common -> element bit
  function automatic logic seg_bit(input logic [7:0] b, input logic hi,
                                   input logic [1:0] com);
    seg_bit = b[{hi, com}]; // [RL2] [RL3]
  endfunction

  // Word accesses pair the even byte with the odd byte above it
  function automatic logic [4:0] pair_addr(input logic [4:0] a,
                                           input logic odd);
    pair_addr = {a[4:1], odd};
  endfunction

  logic tick;
  logic [7:0] ram_reg [lcdx_pkg::RAM_BYTES];
  logic [7:0] ram_next [lcdx_pkg::RAM_BYTES];
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  lcdx_pkg::lcdx_state_t state_reg;
  lcdx_pkg::lcdx_state_t state_next;
  logic [lcdx_pkg::SEG_IDX_W-1:0] idx_reg;
  logic [lcdx_pkg::SEG_IDX_W-1:0] idx_next;
  logic [1:0] com_reg;
  logic [1:0] com_next;
  logic pol_reg;
  logic pol_next;
  logic shift_reg;
  logic shift_next;
  logic latch_reg;
  logic latch_next;
  logic data_reg;
  logic data_next;
  logic [27:0] iseg_reg;
  logic [27:0] iseg_next;
  logic [3:0] com_drv_reg;
  logic [3:0] com_drv_next;
  logic latch_now;

  lcdx_tick_div u_div (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  // Display memory; word access is big-endian on an even address
  always_comb begin
    for (int i = 0; i < lcdx_pkg::RAM_BYTES; i++) begin
      ram_next[i] = ram_reg[i];
    end
    if (cpu_wr_en) begin
      if (cpu_word) begin
        ram_next[pair_addr(cpu_addr, 1'b0)] = cpu_wdata[15:8]; // [RL9] [RL6]
        ram_next[pair_addr(cpu_addr, 1'b1)] = cpu_wdata[7:0]; // [RL9]
      end else begin
        ram_next[cpu_addr] = cpu_wdata[7:0]; // [RL9]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < lcdx_pkg::RAM_BYTES; i++) begin
        ram_reg[i] <= lcdx_pkg::RAM_RESET;
      end
    end else begin
      for (int i = 0; i < lcdx_pkg::RAM_BYTES; i++) begin
        ram_reg[i] <= ram_next[i];
      end
    end
  end

  // A read in the cycle of a write returns the old contents
  always_comb begin
    rdata_next = rdata_reg;
    if (cpu_rd_en) begin
      if (cpu_word) begin
        rdata_next = {ram_reg[pair_addr(cpu_addr, 1'b0)],
                      ram_reg[pair_addr(cpu_addr, 1'b1)]};
      end else begin
        rdata_next = {8'h00, ram_reg[cpu_addr]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // No blanking input: the panel shows memory from the first latch after reset on
  // Scan: per common, shift all 64 bits out, then latch and step
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    com_next = com_reg;
    pol_next = pol_reg;
    shift_next = shift_reg;
    latch_next = latch_reg;
    data_next = data_reg;
    if (tick) begin
      case (state_reg)
        lcdx_pkg::ST_SETUP: begin
          shift_next = 1'b0;
          latch_next = 1'b0;
          // Seg 1 goes out first; XOR keeps the drive AC [RL4] [RL5]
          data_next = seg_bit(ram_reg[idx_reg[5:1]], idx_reg[0],
                              com_reg) ^ pol_reg; // [RL2] [RL7]
          state_next = lcdx_pkg::ST_CLK_HI;
        end
        lcdx_pkg::ST_CLK_HI: begin
          shift_next = 1'b1; // [RL8]
          if (idx_reg == lcdx_pkg::LAST_SEG_IDX) begin
            state_next = lcdx_pkg::ST_LATCH;
          end else begin
            idx_next = idx_reg + 6'h01;
            state_next = lcdx_pkg::ST_SETUP;
          end
        end
        lcdx_pkg::ST_LATCH: begin
          shift_next = 1'b0;
          latch_next = 1'b1; // [RL8]
          idx_next = 6'h00;
          // Panel group takes this same tick through latch_now
          com_next = com_reg + 2'h1; // [RL1]
          // Polarity flips once a frame, after the fourth common
          if (com_reg == 2'h3) begin
            pol_next = ~pol_reg;
          end
          state_next = lcdx_pkg::ST_SETUP;
        end
        default: begin
          state_next = lcdx_pkg::ST_SETUP;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= lcdx_pkg::ST_SETUP;
      idx_reg <= 6'h00;
      com_reg <= 2'h0;
      pol_reg <= 1'b0;
      shift_reg <= 1'b0;
      latch_reg <= 1'b0;
      data_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      com_reg <= com_next;
      pol_reg <= pol_next;
      shift_reg <= shift_next;
      latch_reg <= latch_next;
      data_reg <= data_next;
    end
  end

  // Panel pins switch with the external latch so both halves show one common
  assign latch_now = tick && (state_reg == lcdx_pkg::ST_LATCH);

  always_comb begin
    iseg_next = iseg_reg;
    com_drv_next = com_drv_reg;
    if (latch_now) begin
      for (int k = 0; k < lcdx_pkg::POL_PIN; k++) begin
        iseg_next[k] = seg_bit(ram_reg[k / 2], 1'(k % 2),
                               com_reg) ^ pol_reg; // [RL4] [RL5] [RL7]
      end
      com_drv_next = (4'h1 << com_reg) ^ {4{pol_reg}}; // [RL1]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      iseg_reg <= 28'h000_0000;
      com_drv_reg <= 4'h0;
    end else begin
      iseg_reg <= iseg_next;
      com_drv_reg <= com_drv_next;
    end
  end

  assign cpu_rdata = rdata_reg;
  assign com_out = com_drv_reg;
  assign row_latch_strobe = latch_reg;
  assign shift_strobe = shift_reg;
  assign serial_pixel_out = data_reg;
  assign polarity_out = pol_reg;
  assign seg_out[27:0] = iseg_reg;
  assign seg_out[lcdx_pkg::POL_PIN] = pol_reg; // [RL8]
  assign seg_out[lcdx_pkg::DATA_PIN] = data_reg; // [RL8]
  assign seg_out[lcdx_pkg::SHIFT_PIN] = shift_reg; // [RL8]
  assign seg_out[lcdx_pkg::LATCH_PIN] = latch_reg; // [RL8]
endmodule

// file: tb/lcdx_ctrl_props.sv
`timescale 1ns/100ps
module lcdx_ctrl_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] com_out,
  input wire logic [31:0] seg_out,
  input wire logic row_latch_strobe,
  input wire logic shift_strobe,
  input wire logic serial_pixel_out,
  input wire logic polarity_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // One tick is 16 clocks
  sequence hold16(s);
    s[*8] ##1 s[*8];
  endsequence
  a_pol_pin: assert property (seg_out[28] == polarity_out)
    else $error("polarity pin differs");
  a_data_pin: assert property (seg_out[29] == serial_pixel_out)
    else $error("data pin differs");
  a_shift_pin: assert property (seg_out[30] == shift_strobe)
    else $error("shift pin differs");
  a_latch_pin: assert property (seg_out[31] == row_latch_strobe)
    else $error("latch pin differs");
  a_shift_high: assert property ($rose(shift_strobe) |->
    hold16(shift_strobe) ##1 !shift_strobe) else $error("bad shift high");
  a_shift_low: assert property ($fell(shift_strobe) |->
    hold16(!shift_strobe)) else $error("shift low too short");
  a_latch_len: assert property ($rose(row_latch_strobe) |->
    hold16(row_latch_strobe) ##1 !row_latch_strobe) else $error("bad latch");
  a_data_hold: assert property (shift_strobe |->
    $stable(serial_pixel_out)) else $error("data moved while shifting");
  a_com_moves: assert property ($changed(com_out) |->
    row_latch_strobe) else $error("common moved outside latch");
  a_latch_excl: assert property (!(row_latch_strobe && shift_strobe))
    else $error("latch during shift");
endmodule
bind lcdx_ctrl lcdx_ctrl_props lcdx_ctrl_props_i (.clk, .rst, .com_out,
  .seg_out, .row_latch_strobe, .shift_strobe, .serial_pixel_out,
  .polarity_out);

// file: tb/lcdx_seg_ext.sv
`timescale 1ns/100ps
module lcdx_seg_ext (
  input wire logic clk,
  input wire logic shift_strobe,
  input wire logic row_latch_strobe,
  input wire logic serial_pixel_out,
  output logic [63:0] row,
  output logic [7:0] n_sh,
  output logic new_row
);
  logic sh_d = 0, la_d = 0;
  logic [63:0] sr;
  logic [7:0] cnt = 8'h00;
  initial new_row = 0;
  always @(posedge clk) begin
    sh_d <= shift_strobe;
    la_d <= row_latch_strobe;
    new_row <= 0;
    if (shift_strobe && !sh_d) begin
      sr <= {serial_pixel_out, sr[63:1]};
      cnt <= cnt + 8'h01;
    end
    if (row_latch_strobe && !la_d) begin
      row <= sr;
      n_sh <= cnt;
      cnt <= 8'h00;
      new_row <= 1;
    end
  end
endmodule

// file: tb/tb_lcdx_ctrl.sv
`timescale 1ns/100ps
module tb_lcdx_ctrl;
  logic clk = 0, rst = 1, cpu_wr_en = 0, cpu_rd_en = 0, cpu_word = 0;
  logic [4:0] cpu_addr = 5'h00;
  logic [15:0] cpu_wdata = 16'h0000, cpu_rdata;
  logic [3:0] com_out;
  logic [31:0] seg_out;
  logic row_latch_strobe, shift_strobe, serial_pixel_out, polarity_out;
  logic new_row, rd_d = 0;
  logic [63:0] row;
  logic [7:0] n_sh, hb, lf = 8'h61, mem [32];
  logic [68:0] eq [$];
  logic [15:0] rq [$];
  int bad_count = 0, total_checks = 0, nrow = 0;
  always #5 clk = ~clk;
  lcdx_ctrl lcdx_ctrl_i (.clk, .rst, .cpu_wr_en, .cpu_rd_en, .cpu_word,
    .cpu_addr, .cpu_wdata, .cpu_rdata, .com_out, .seg_out,
    .row_latch_strobe, .shift_strobe, .serial_pixel_out, .polarity_out);
  lcdx_seg_ext lcdx_seg_ext_i (.clk, .shift_strobe, .row_latch_strobe,
    .serial_pixel_out, .row, .n_sh, .new_row);
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [63:0] erow(input int c, input logic p);
    logic [63:0] r;
    for (int s = 0; s < 64; s++) r[s] = mem[s / 2][(s % 2) * 4 + c] ^ p;
    return r;
  endfunction
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Reads note their expectation; writes update the shadow memory
  task acc(input logic w, input logic rd, input logic [4:0] a,
           input logic [15:0] d);
    @(posedge clk);
    cpu_wr_en <= !rd;
    cpu_rd_en <= rd;
    cpu_word <= w;
    cpu_addr <= a;
    cpu_wdata <= d;
    if (rd) rq.push_back(d);
    else if (w) {mem[{a[4:1], 1'b0}], mem[{a[4:1], 1'b1}]} = d;
    else mem[a] = d[7:0];
    @(posedge clk);
    cpu_wr_en <= 0;
    cpu_rd_en <= 0;
  endtask
  always @(posedge clk) begin
    rd_d <= cpu_rd_en;
    if (rd_d) chk(64'(cpu_rdata), 64'(rq.pop_front()));
    if (new_row) begin
      chk(64'(n_sh), 64'h40);
      nrow++;
      // First frame overlaps the initial writes, so it is not compared
      if (nrow > 4) begin
        chk(row, eq[0][63:0]);
        chk(64'(com_out), 64'(eq[0][67:64]));
        chk(64'(seg_out[27:0]), 64'(eq[0][27:0]));
        chk(64'(polarity_out), 64'(eq[0][68]));
        void'(eq.pop_front());
      end
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    chk(64'(seg_out), 64'h0);
    rst <= 0;
    acc(1'b0, 1'b1, 5'h1f, 16'h0000);
    // Odd addresses on some word writes: bit 0 must be ignored
    for (int i = 0; i < 32; i += 2) begin
      lf = nx(lf);
      hb = lf;
      lf = nx(lf);
      acc(1'b1, 1'b0, 5'(i) | {4'h0, i[1]}, {hb, lf});
    end
    acc(1'b0, 1'b0, 5'h00, 16'h0062);
    acc(1'b0, 1'b0, 5'h01, 16'h0046);
    acc(1'b1, 1'b1, 5'h01, 16'h6246);
    acc(1'b0, 1'b1, 5'h05, {8'h00, mem[5]});
    wait (nrow == 4);
    for (int k = 4; k < 12; k++)
      eq.push_back({k[2] ^ (k % 4 == 3), 4'(1 << (k % 4)) ^ {4{k[2]}},
        erow(k % 4, k[2])});
    wait (eq.size() == 0);
    @(posedge clk);
    end_of_test();
  end
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
endmodule
